// ==== iseq_top.sv ====
// interrupt latching, priority, vectoring and context sequencing
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps

// Operation
// (R1) maskable requests serviced only with mask clear; masked requests stay latched
// (R2) entry waits for the current instruction to end
// (R3) entry pushes pc, x, a and condition code register onto stack
// (R4) entry sets the global mask bit
// (R5) pc loaded from the two-byte vector of the serviced source
// (R6) return instruction pops context, restoring mask bit, and resumes
// (R7) fixed priority, higher vector address wins
// (R8) trap enters at FFFC regardless of mask; never wakes from halt
// (R9) four external vectors FFF6 down to FFF0, one per pin group
// (R10) peripheral vectors FFEC down to FFE4, one per peripheral
// (R11) any source wakes from wait
// (R12) only external sources wake from halt
// (R13) external vector needs its event and clear mask; wakes halt
// (R14) edge requests latched, cleared on entering their handler
// (R15) enabled pins of a group are ANDed before detection
// (R16) sensitivity applies to the ANDed level, low pin blocks
// (R17) polarity chosen by fields in the miscellaneous register
// (R18) peripheral flag requests only with mask clear and enable set
// (R19) peripheral request cleared by writing 0 or flag access sequence
// (R20) clearing sequence discards a pending masked or disabled request
// (R21) polarity 00 fall+low, 10 fall, 01 rise, 11 both
// (R22) changing a polarity field clears its vectors' pending requests
// (R23) shared peripheral vector requests when any flag with its enable
// (R24) reset sets mask, clears latches, polarity back to default
module iseq_top
  import iseq_pkg::*;
#(
  parameter int NFLAG = 5
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core
  input wire iseq_ctx_t cpu_ctx,
  input wire logic cpu_instr_end,
  input wire logic cpu_trap,
  input wire logic cpu_return_from_handler_instruction,
  input wire logic cpu_wfi,
  input wire logic cpu_halt,
  input wire logic cpu_mask_set,
  input wire logic cpu_mask_clr,
  output logic core_stall,
  output iseq_ctx_t ctx_out,
  output logic ctx_load,
  output logic imask,
  output logic wait_mode,
  output logic halt_mode,
  // stack and vector memory
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  // external pins and their interrupt enables
  input wire logic [ISEQ_NPIN-1:0] ext_pins,
  input wire logic [ISEQ_NPIN-1:0] ext_pin_en,
  // peripheral flags, enables and clear-sequence pulses
  input wire logic [ISEQ_NPER-1:0][NFLAG-1:0] per_flag,
  input wire logic [ISEQ_NPER-1:0][NFLAG-1:0] per_en,
  input wire logic [ISEQ_NPER-1:0] per_clr
);

  // ==========================================================
  // declarations
  iseq_state_t st;
  iseq_state_t nx;
  logic [ISEQ_NEXT-1:0] grp_lvl;
  logic [ISEQ_NEXT-1:0] grp_act;
  logic [ISEQ_NEXT-1:0] lvl_en;
  logic [ISEQ_NEXT-1:0] edge_hit;
  logic [ISEQ_NEXT-1:0] ext_pend;
  logic [ISEQ_NEXT-1:0] pol_chg;
  logic [ISEQ_NPER-1:0] per_any;
  logic [ISEQ_NPER-1:0] per_req;
  logic [ISEQ_NSRC-1:0] req;
  logic [3:0] src;
  logic go;
  logic wr_acc;
  logic [1:0] pol_lo_new;
  logic [1:0] pol_hi_new;

  // ==========================================================
  // external groups: and, detect, latch
  assign wr_acc = psel & penable & pwrite & st.pready;
  assign pol_lo_new = pwdata[ISEQ_POL_LO_POS+1:ISEQ_POL_LO_POS];
  assign pol_hi_new = pwdata[ISEQ_POL_HI_POS+1:ISEQ_POL_HI_POS];

  genvar g;
  generate
    for (g = 0; g < ISEQ_NEXT; g++)
    begin : g_ext
      logic [ISEQ_NPIN-1:0] sel;
      logic [1:0] pol;
      logic [1:0] pol_new;
      assign sel = ext_pin_en & ISEQ_GRP_MASK[g];
      assign grp_act[g] = |sel;
      // enabled pins combined before detection; idle high with none enabled
      assign grp_lvl[g] = &(st.pin_st | ~sel); // R15
      assign pol = (g < 2) ? st.misc[ISEQ_POL_LO_POS+1:ISEQ_POL_LO_POS]
                           : st.misc[ISEQ_POL_HI_POS+1:ISEQ_POL_HI_POS]; // R17
      assign pol_new = (g < 2) ? pol_lo_new : pol_hi_new;
      // 00 fall and low, 10 fall, 01 rise, 11 both; upper bit first
      assign lvl_en[g] = (pol == 2'b00); // R21
      assign edge_hit[g] = grp_act[g] & ((st.grp_prev[g] & ~grp_lvl[g] & (~pol[0] | pol[1]))
                         | (~st.grp_prev[g] & grp_lvl[g] & pol[0])); // R16 R21
      assign ext_pend[g] = st.ext_edge[g] | (lvl_en[g] & grp_act[g] & ~grp_lvl[g]);
      assign pol_chg[g] = wr_acc && paddr == ISEQ_MISC_OFF && pol_new != pol; // R22
    end
  endgenerate

  // ==========================================================
  // peripheral request logic
  generate
    for (g = 0; g < ISEQ_NPER; g++)
    begin : g_per
      assign per_any[g] = |per_flag[g];
      // any flag of the peripheral together with its own enable
      assign per_req[g] = st.per_lat[g] & (|(per_flag[g] & per_en[g])); // R18 R23
    end
  endgenerate

  // maskable sources only count with the mask clear; trap always
  assign req = {per_req & {ISEQ_NPER{~st.imask}},
                ext_pend & {ISEQ_NEXT{~st.imask}},
                cpu_trap & cpu_instr_end}; // R1 R8 R13
  // boundary of an instruction, or parked in wait, or back from halt
  assign go = cpu_instr_end | st.wait_m | st.resume; // R2 R11

  // fixed priority: lowest code, i.e. highest vector, wins
  always_comb
  begin
    src = 4'h0;
    for (int i = ISEQ_NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        src = 4'(i); // R7
      end
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nx = st;
    nx.ctx_load = 1'b0;
    nx.mem_we = 1'b0;
    nx.mem_re = 1'b0;
    // three-stage pin synchroniser, change taken when stages 2 and 3 agree
    nx.s1 = ext_pins;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    nx.pin_st = (st.s2 & st.s3) | (st.pin_st & (st.s2 ^ st.s3));
    nx.grp_prev = grp_lvl;
    // edge latch: new edge wins over any clear in the same cycle
    nx.ext_edge = edge_hit | (st.ext_edge & ~pol_chg); // R14 R22
    // peripheral latch: clear sequence discards, new flag wins
    nx.per_prev = per_any;
    nx.per_lat = (per_any & ~st.per_prev) | (st.per_lat & ~per_clr); // R19 R20
    if (cpu_mask_set)
    begin
      nx.imask = 1'b1;
    end
    else if (cpu_mask_clr)
    begin
      nx.imask = 1'b0;
    end
    // apb slave, zero wait states
    nx.pready = psel & ~penable;
    nx.pslverr = psel & ~penable & paddr != ISEQ_MISC_OFF & paddr != ISEQ_STAT_OFF;
    if (psel & ~penable)
    begin
      case (paddr)
        ISEQ_MISC_OFF: nx.prdata = {24'h000000, st.misc};
        ISEQ_STAT_OFF: nx.prdata = {20'h00000, st.halt_m, st.wait_m, st.imask,
                                    st.per_lat, ext_pend};
        default: nx.prdata = 32'h00000000;
      endcase
    end
    if (wr_acc && paddr == ISEQ_MISC_OFF)
    begin
      nx.misc = pwdata[7:0]; // R17
    end
    case (st.fsm)
      ISEQ_S_IDLE:
      begin
        if (go && req != '0)
        begin
          // accept: save pcl first, mask, pick vector
          nx.fsm = ISEQ_S_PUSH;
          nx.cnt = '0;
          nx.src = src;
          nx.stall = 1'b1;
          nx.ctx = cpu_ctx;
          nx.ctx.cc[ISEQ_CC_I] = st.imask;
          nx.mem_we = 1'b1; // R3
          nx.mem_addr = {ISEQ_STK_PAGE, st.sp};
          nx.mem_wdata = cpu_ctx.pc[7:0];
          nx.sp = st.sp - 8'h01;
          nx.imask = 1'b1; // R4
          nx.wait_m = 1'b0;
          nx.resume = 1'b0;
          if (src == ISEQ_SRC_TRAP)
          begin
            nx.vec = ISEQ_VEC_TRAP; // R8
          end
          else if (src < ISEQ_SRC_PER0)
          begin
            nx.vec = ISEQ_VEC_EXT0 - 16'({src - ISEQ_SRC_EXT0, 1'b0}); // R9
            nx.ext_edge[2'(src - ISEQ_SRC_EXT0)] = edge_hit[2'(src - ISEQ_SRC_EXT0)]; // R14
          end
          else
          begin
            nx.vec = ISEQ_VEC_PER0 - 16'({src - ISEQ_SRC_PER0, 1'b0}); // R10
          end
        end
        else if (cpu_return_from_handler_instruction && cpu_instr_end)
        begin
          // pop starts with the byte above the stack pointer
          nx.fsm = ISEQ_S_POP;
          nx.cnt = '0;
          nx.stall = 1'b1;
          nx.mem_re = 1'b1; // R6
          nx.mem_addr = {ISEQ_STK_PAGE, st.sp + 8'h01};
          nx.sp = st.sp + 8'h01;
        end
        else if (st.halt_m && (ext_pend != '0))
        begin
          // only external events restart the oscillator
          nx.fsm = ISEQ_S_STAB; // R12 R13
          nx.cnt = '0;
        end
        else if (cpu_wfi && cpu_instr_end)
        begin
          nx.wait_m = 1'b1;
          nx.imask = 1'b0;
        end
        else if (cpu_halt && cpu_instr_end)
        begin
          nx.halt_m = 1'b1;
          nx.imask = 1'b0;
        end
      end
      ISEQ_S_PUSH:
      begin
        if (st.cnt == ISEQ_PUSH_LAST)
        begin
          nx.fsm = ISEQ_S_VEC;
          nx.cnt = '0;
          nx.mem_re = 1'b1; // R5
          nx.mem_addr = st.vec;
        end
        else
        begin
          nx.cnt = st.cnt + 13'h0001;
          nx.mem_we = 1'b1; // R3
          nx.mem_addr = {ISEQ_STK_PAGE, st.sp};
          nx.sp = st.sp - 8'h01;
          case (st.cnt[1:0])
            2'b00: nx.mem_wdata = st.ctx.pc[15:8];
            2'b01: nx.mem_wdata = st.ctx.x;
            2'b10: nx.mem_wdata = st.ctx.a;
            default: nx.mem_wdata = st.ctx.cc;
          endcase
        end
      end
      ISEQ_S_VEC:
      begin
        nx.cnt = st.cnt + 13'h0001;
        if (st.cnt == '0)
        begin
          nx.mem_re = 1'b1;
          nx.mem_addr = st.vec + 16'h0001;
        end
        else if (st.cnt != ISEQ_VEC_LAST)
        begin
          nx.ctx.pc[15:8] = mem_rdata;
        end
        else
        begin
          // handler address now presented to the core
          nx.ctx.pc[7:0] = mem_rdata; // R5
          nx.ctx_load = 1'b1;
          nx.stall = 1'b0;
          nx.fsm = ISEQ_S_IDLE;
        end
      end
      ISEQ_S_POP:
      begin
        nx.cnt = st.cnt + 13'h0001;
        if (st.cnt < ISEQ_PUSH_LAST)
        begin
          nx.mem_re = 1'b1;
          nx.mem_addr = {ISEQ_STK_PAGE, st.sp + 8'h01};
          nx.sp = st.sp + 8'h01;
        end
        case (st.cnt[2:0])
          3'b001:
          begin
            nx.ctx.cc = mem_rdata;
            nx.imask = mem_rdata[ISEQ_CC_I]; // R6
          end
          3'b010: nx.ctx.a = mem_rdata;
          3'b011: nx.ctx.x = mem_rdata;
          3'b100: nx.ctx.pc[15:8] = mem_rdata;
          3'b101: nx.ctx.pc[7:0] = mem_rdata;
          default: nx.ctx.cc = st.ctx.cc;
        endcase
        if (st.cnt == ISEQ_POP_LAST)
        begin
          nx.ctx_load = 1'b1; // R6
          nx.stall = 1'b0;
          nx.fsm = ISEQ_S_IDLE;
        end
      end
      ISEQ_S_STAB:
      begin
        // oscillator settling time before the wake-up source is served
        nx.cnt = st.cnt + 13'h0001;
        if (st.cnt == ISEQ_STAB_CYC - 13'h0001)
        begin
          nx.halt_m = 1'b0;
          nx.resume = 1'b1;
          nx.fsm = ISEQ_S_IDLE;
        end
      end
      default:
      begin
        nx.fsm = ISEQ_S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.sp <= ISEQ_SP_RST;
      st.imask <= 1'b1; // R24
      st.misc <= ISEQ_MISC_RST; // R24
    end
    else
    begin
      st <= nx;
    end
  end

  // outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign core_stall = st.stall;
  assign ctx_out = st.ctx;
  assign ctx_load = st.ctx_load;
  assign imask = st.imask;
  assign wait_mode = st.wait_m;
  assign halt_mode = st.halt_m;
  assign mem_addr = st.mem_addr;
  assign mem_wdata = st.mem_wdata;
  assign mem_we = st.mem_we;
  assign mem_re = st.mem_re;

  // ==========================================================
  // assertions
  logic [ISEQ_NSRC-1:0] req_q;
  logic [ISEQ_NSRC-1:0] lower_q;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      req_q <= '0;
    end
    else
    begin
      req_q <= req;
    end
  end
  assign lower_q = (10'h001 << st.src) - 10'h001;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  mask_gate_a: assert property (($rose(st.mem_we) && st.src != ISEQ_SRC_TRAP)
    |-> $past(!st.imask)) else $error("maskable entry while masked"); // R1
  entry_boundary_a: assert property (($rose(st.mem_we) && !$past(st.wait_m)
    && !$past(st.resume)) |-> $past(cpu_instr_end))
    else $error("entry outside instruction boundary"); // R2
  push_five_a: assert property ($rose(st.mem_we) |-> st.mem_we [*5]
    ##1 (st.mem_re && st.mem_addr == st.vec))
    else $error("context push not five bytes"); // R3
  entry_mask_a: assert property ($rose(st.mem_we) |-> st.imask && st.stall)
    else $error("mask not set on entry"); // R4
  vector_load_a: assert property ((st.fsm == ISEQ_S_VEC && st.cnt == ISEQ_VEC_LAST)
    |=> st.ctx_load && st.ctx.pc == {$past(mem_rdata, 2), $past(mem_rdata)})
    else $error("pc not loaded from vector"); // R5
  pop_mask_a: assert property ((st.fsm == ISEQ_S_POP && st.cnt == ISEQ_POP_LAST)
    |=> st.ctx_load && st.imask == st.ctx.cc[ISEQ_CC_I])
    else $error("mask not restored by return"); // R6
  prio_pick_a: assert property ($rose(st.mem_we) |-> (req_q & lower_q) == '0)
    else $error("lower priority source served first"); // R7
  trap_entry_a: assert property ((st.fsm == ISEQ_S_IDLE && cpu_trap && cpu_instr_end)
    |=> st.mem_we && st.vec == ISEQ_VEC_TRAP)
    else $error("trap not entered"); // R8
  halt_hold_a: assert property ((st.fsm == ISEQ_S_IDLE && st.halt_m && !st.resume
    && ext_pend == '0) |=> st.halt_m)
    else $error("non external source left halt"); // R12

  trap_seen_c: cover property ($rose(st.mem_we) && st.src == ISEQ_SRC_TRAP);
  ext_seen_c: cover property ($rose(st.mem_we) && st.src == ISEQ_SRC_EXT0);
  per_seen_c: cover property ($rose(st.mem_we) && st.src >= ISEQ_SRC_PER0);
  pop_seen_c: cover property (st.fsm == ISEQ_S_POP && st.cnt == ISEQ_POP_LAST);
  halt_wake_c: cover property ($fell(st.halt_m));

endmodule

// ==== iseq_pkg.sv ====
// package of constants and types for the interrupt sequencer
package iseq_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] ISEQ_MISC_OFF = 12'h020;
  localparam logic [11:0] ISEQ_STAT_OFF = 12'h024;
  localparam logic [7:0] ISEQ_MISC_RST = 8'h00;
  // polarity field positions inside the miscellaneous register
  localparam int ISEQ_POL_LO_POS = 3;
  localparam int ISEQ_POL_HI_POS = 6;

  // ==========================================================
  // vectors
  localparam logic [15:0] ISEQ_VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] ISEQ_VEC_EXT0 = 16'hFFF6;
  localparam logic [15:0] ISEQ_VEC_PER0 = 16'hFFEC;

  // ==========================================================
  // sources: code 0 trap, 1..4 external groups, 5..9 peripherals
  localparam int ISEQ_NEXT = 4;
  localparam int ISEQ_NPER = 5;
  localparam int ISEQ_NSRC = 10;
  localparam int ISEQ_NPIN = 15;
  localparam logic [3:0] ISEQ_SRC_TRAP = 4'h0;
  localparam logic [3:0] ISEQ_SRC_EXT0 = 4'h1;
  localparam logic [3:0] ISEQ_SRC_PER0 = 4'h5;
  // pins: [3:0] port a, [6:4] port f, [10:7] port b low, [14:11] port b high
  localparam logic [ISEQ_NEXT-1:0][ISEQ_NPIN-1:0] ISEQ_GRP_MASK =
    {15'h7800, 15'h0780, 15'h0070, 15'h000F};

  // ==========================================================
  // stack and timing
  localparam logic [7:0] ISEQ_STK_PAGE = 8'h01;
  localparam logic [7:0] ISEQ_SP_RST = 8'hFF;
  localparam int ISEQ_CC_I = 3;
  localparam logic [12:0] ISEQ_STAB_CYC = 13'h1000;
  localparam logic [12:0] ISEQ_PUSH_LAST = 13'h0004;
  localparam logic [12:0] ISEQ_POP_LAST = 13'h0005;
  localparam logic [12:0] ISEQ_VEC_LAST = 13'h0002;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ISEQ_S_IDLE = 3'b000,
    ISEQ_S_PUSH = 3'b001,
    ISEQ_S_VEC = 3'b010,
    ISEQ_S_POP = 3'b011,
    ISEQ_S_STAB = 3'b100
  } iseq_fsm_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] cc;
  } iseq_ctx_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } iseq_mem_t;

  typedef struct packed {
    iseq_fsm_t fsm;
    logic [12:0] cnt;
    logic [3:0] src;
    logic [15:0] vec;
    logic [7:0] misc;
    logic imask;
    logic [7:0] sp;
    logic [ISEQ_NPIN-1:0] s1;
    logic [ISEQ_NPIN-1:0] s2;
    logic [ISEQ_NPIN-1:0] s3;
    logic [ISEQ_NPIN-1:0] pin_st;
    logic [ISEQ_NEXT-1:0] grp_prev;
    logic [ISEQ_NEXT-1:0] ext_edge;
    logic [ISEQ_NPER-1:0] per_lat;
    logic [ISEQ_NPER-1:0] per_prev;
    logic wait_m;
    logic halt_m;
    logic resume;
    logic stall;
    iseq_ctx_t ctx;
    logic ctx_load;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } iseq_state_t;

endpackage

// ==== iseq_stub.sv ====
// no further logic in this file
`timescale 1ns/10ps

// ==== iseq_cpu_model.sv ====
// core and memory model on the far side of the interrupt sequencer
`timescale 1ns/10ps
module iseq_cpu_model
  import iseq_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bench command: 1 trap, 2 return, 3 wait, 4 halt
  input wire logic [2:0] op,
  // sequencer side
  input wire logic core_stall,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [7:0] mem_rdata,
  output logic cpu_instr_end,
  output logic cpu_trap,
  output logic cpu_return_from_handler_instruction,
  output logic cpu_wfi,
  output logic cpu_halt,
  output iseq_ctx_t cpu_ctx
);
  logic [7:0] mem [0:65535];
  logic [1:0] div;
  logic [2:0] pend;

  // ==========================================================
  // instruction boundaries every four cycles, none while stopped
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      div <= 2'h0;
      pend <= 3'h0;
      cpu_instr_end <= 1'h0;
    end
    else
    begin
      div <= div + 2'h1;
      cpu_instr_end <= (div == 2'h3) && !core_stall && !wait_mode && !halt_mode;
      if (op != 3'h0)
        pend <= op;
      else if (cpu_instr_end)
        pend <= 3'h0;
    end
  end

  // commands leave only at a boundary
  assign cpu_trap = cpu_instr_end && (pend == 3'h1);
  assign cpu_return_from_handler_instruction = cpu_instr_end && (pend == 3'h2);
  assign cpu_wfi = cpu_instr_end && (pend == 3'h3);
  assign cpu_halt = cpu_instr_end && (pend == 3'h4);
  assign cpu_ctx = {16'h1234, 8'h56, 8'h78, 8'h00};

  // ==========================================================
  // memory: each byte preset to its low address byte
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = i[7:0];
    mem_rdata = 8'h00;
  end

  // read data one cycle after the strobe, scrambled otherwise
  always @(posedge clk_sys)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
  end
endmodule

// ==== tb_mcu_interrupt_sequencer.sv ====
// self-checking testbench of the interrupt sequencer
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module tb_mcu_interrupt_sequencer
  import iseq_pkg::*;
;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic cpu_mask_set = 1'h0, cpu_mask_clr = 1'h0;
  logic [2:0] op = 3'h0;
  logic [ISEQ_NPIN-1:0] ext_pins = 15'h7FFF, ext_pin_en = 15'h0000;
  logic [ISEQ_NPER-1:0][4:0] per_flag = 25'h0, per_en = 25'h0;
  logic [ISEQ_NPER-1:0] per_clr = 5'h0;
  iseq_ctx_t cpu_ctx, ctx_out;
  logic cpu_instr_end, cpu_trap, cpu_return_from_handler_instruction, cpu_wfi, cpu_halt;
  logic core_stall, ctx_load, imask, wait_mode, halt_mode, mem_we, mem_re;
  logic [15:0] mem_addr, v;
  logic [7:0] mem_wdata, mem_rdata;
  logic [23:0] wq[$];
  int error_cnt = 0, checked = 0, cyc = 0, nload = 0, n0;

  // ==========================================================
  // design and partner
  iseq_top #(.NFLAG(5)) i_dut (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_ctx(cpu_ctx), .cpu_instr_end(cpu_instr_end), .cpu_trap(cpu_trap),
    .cpu_return_from_handler_instruction(cpu_return_from_handler_instruction), .cpu_wfi(cpu_wfi), .cpu_halt(cpu_halt),
    .cpu_mask_set(cpu_mask_set), .cpu_mask_clr(cpu_mask_clr), .core_stall(core_stall),
    .ctx_out(ctx_out), .ctx_load(ctx_load), .imask(imask), .wait_mode(wait_mode),
    .halt_mode(halt_mode), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata), .ext_pins(ext_pins), .ext_pin_en(ext_pin_en),
    .per_flag(per_flag), .per_en(per_en), .per_clr(per_clr));
  iseq_cpu_model i_cpu (
    .clk_sys(clk_sys), .nrst(nrst), .op(op), .core_stall(core_stall),
    .wait_mode(wait_mode), .halt_mode(halt_mode), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
    .cpu_instr_end(cpu_instr_end), .cpu_trap(cpu_trap), .cpu_return_from_handler_instruction(cpu_return_from_handler_instruction),
    .cpu_wfi(cpu_wfi), .cpu_halt(cpu_halt), .cpu_ctx(cpu_ctx));

  // clock of 40 ns
  always #20 clk_sys = ~clk_sys;

  // stack write log, load count and hang limit
  always @(posedge clk_sys)
  begin
    cyc++;
    if (mem_we === 1'h1)
      wq.push_back({mem_addr, mem_wdata});
    if (ctx_load === 1'h1)
      nload++;
    if (cyc == 40000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================================
  // tasks
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer, idle edge after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask

  // read and compare masked bits
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rd & m, e)
  endtask

  task automatic msk(input logic s);
    cpu_mask_set <= s;
    cpu_mask_clr <= !s;
    @(posedge clk_sys);
    cpu_mask_set <= 1'h0;
    cpu_mask_clr <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic cmd(input logic [2:0] c);
    op <= c;
    @(posedge clk_sys);
    op <= 3'h0;
    @(posedge clk_sys);
  endtask

  // wait for a context load and compare the loaded pc
  task automatic wload(input logic [15:0] e);
    int n;
    n = 0;
    while (ctx_load !== 1'h1 && n < 6000)
    begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(ctx_out.pc, e)
    @(posedge clk_sys);
  endtask

  task automatic ret;
    cmd(3'h2);
    wload(16'h1234);
  endtask

  task automatic clr_per(input int p);
    per_flag[p] <= 5'h00;
    per_en[p] <= 5'h00;
    per_clr[p] <= 1'h1;
    @(posedge clk_sys);
    per_clr[p] <= 1'h0;
    @(posedge clk_sys);
  endtask

  // ==========================================================
  // scenarios
  initial
  begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'h1;
    `CHK(imask, 1'h1)
    rc(ISEQ_MISC_OFF, 32'hFF, 32'h00);
    rc(ISEQ_STAT_OFF, 32'hFFF, 32'h200);
    apb(1'h0, 12'h0FC, 32'h0);
    `CHK(er, 1'h1)
    // low level on a two-pin group, masked then unmasked
    ext_pin_en <= 15'h0003;
    ext_pins[0] <= 1'h0;
    repeat (20) @(posedge clk_sys);
    `CHK(nload, 0)
    msk(1'h0);
    wload(16'hF6F7);
    `CHK(imask, 1'h1)
    `CHK(core_stall, 1'h0)
    `CHK(wq[0], {16'h01FF, 8'h34})
    `CHK(wq[4], {16'h01FB, 8'h00})
    ext_pins[0] <= 1'h1;
    ret();
    `CHK(imask, 1'h0)
    // latched edge and shared peripheral flag, priority order
    msk(1'h1);
    apb(1'h1, ISEQ_MISC_OFF, 32'h10);
    ext_pin_en <= 15'h0071;
    per_flag[0][1] <= 1'h1;
    per_en[0][1] <= 1'h1;
    ext_pins[5] <= 1'h0;
    repeat (10) @(posedge clk_sys);
    rc(ISEQ_STAT_OFF, 32'hFFF, 32'h212);
    ext_pins[5] <= 1'h1;
    msk(1'h0);
    wload(16'hF4F5);
    rc(ISEQ_STAT_OFF, 32'h00F, 32'h0);
    ret();
    wload(16'hECED);
    clr_per(0);
    ret();
    // disabled request discarded by the clear sequence
    n0 = nload;
    per_flag[1][0] <= 1'h1;
    repeat (10) @(posedge clk_sys);
    rc(ISEQ_STAT_OFF, 32'h020, 32'h020);
    per_clr[1] <= 1'h1;
    @(posedge clk_sys);
    per_clr[1] <= 1'h0;
    per_en[1][0] <= 1'h1;
    repeat (20) @(posedge clk_sys);
    `CHK(nload, n0)
    per_en[1][0] <= 1'h0;
    clr_per(1);
    // trap while masked
    msk(1'h1);
    cmd(3'h1);
    wload(16'hFCFD);
    ret();
    // polarity modes and clearing on change
    apb(1'h1, ISEQ_MISC_OFF, 32'h90);
    ext_pin_en <= 15'h0080;
    ext_pins[7] <= 1'h0;
    repeat (10) @(posedge clk_sys);
    rc(ISEQ_STAT_OFF, 32'h00F, 32'h004);
    apb(1'h1, ISEQ_MISC_OFF, 32'hD0);
    rc(ISEQ_STAT_OFF, 32'h00F, 32'h000);
    ext_pins[7] <= 1'h1;
    repeat (10) @(posedge clk_sys);
    rc(ISEQ_STAT_OFF, 32'h00F, 32'h004);
    apb(1'h1, ISEQ_MISC_OFF, 32'h50);
    rc(ISEQ_STAT_OFF, 32'h00F, 32'h000);
    // low pin blocks rising edge of its group
    ext_pin_en <= 15'h1800;
    ext_pins[12:11] <= 2'h0;
    repeat (10) @(posedge clk_sys);
    ext_pins[11] <= 1'h1;
    repeat (10) @(posedge clk_sys);
    rc(ISEQ_STAT_OFF, 32'h00F, 32'h000);
    ext_pins[12] <= 1'h1;
    repeat (10) @(posedge clk_sys);
    rc(ISEQ_STAT_OFF, 32'h00F, 32'h008);
    apb(1'h1, ISEQ_MISC_OFF, 32'h10);
    ext_pin_en <= 15'h0070;
    // halt: peripheral stays asleep, external wakes
    cmd(3'h4);
    repeat (12) @(posedge clk_sys);
    per_flag[2][0] <= 1'h1;
    per_en[2][0] <= 1'h1;
    repeat (50) @(posedge clk_sys);
    `CHK(halt_mode, 1'h1)
    ext_pins[5] <= 1'h0;
    wload(16'hF4F5);
    `CHK(halt_mode, 1'h0)
    ext_pins[5] <= 1'h1;
    clr_per(2);
    ret();
    // every peripheral wakes from wait at its own vector
    for (int p = 0; p < ISEQ_NPER; p++)
    begin
      cmd(3'h3);
      repeat (10) @(posedge clk_sys);
      `CHK(wait_mode, 1'h1)
      per_flag[p][0] <= 1'h1;
      per_en[p][0] <= 1'h1;
      v = 16'hFFEC - 16'(2 * p);
      wload({v[7:0], v[7:0] + 8'h01});
      clr_per(p);
      ret();
    end
    end_of_test();
  end
endmodule
